// ---- pkg/abs_readout_pkg.sv ----
package abs_readout_pkg;

   // Clock and time base
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
   localparam int unsigned TS_ADD_MIN_MS = 2;
   localparam int unsigned TR_MAX_MS = 200;
   localparam int unsigned TQ_MS = 1;
   localparam int unsigned TN_MS = 1;
   localparam int unsigned TIME_W = 40;

   // Frame geometry
   localparam int unsigned FRAME_BITS = 80;
   localparam logic [6:0] LAST_BIT = 7'h4f;

   // Parameter addresses
   localparam logic [15:0] ADDR_SNAPSHOT = 16'h0062;
   localparam logic [15:0] ADDR_STATUS = 16'h0064;
   localparam logic [15:0] ADDR_TURNS = 16'h0066;
   localparam logic [15:0] ADDR_PULSE = 16'h0068;
   localparam logic [15:0] ADDR_UNLOCK = 16'h0210;
   localparam logic [15:0] ADDR_DEBOUNCE = 16'h0212;
   localparam logic [15:0] ADDR_ENC_MODE = 16'h028a;
   localparam logic [15:0] ADDR_FORMAT = 16'h028c;
   localparam logic [15:0] ADDR_HOMING = 16'h028e;

   // Reset values
   localparam logic [15:0] RST_PARAM16 = 16'h0000;
   localparam logic [31:0] RST_PARAM32 = 32'h0000_0000;
   localparam logic [15:0] RST_DEBOUNCE = 16'h0002;

   // Command values and masks
   localparam logic [15:0] UNLOCK_KEY = 16'h010f;
   localparam logic [15:0] HOME_GO = 16'h0001;
   localparam logic [15:0] SNAP_READ = 16'h0001;
   localparam logic [15:0] SNAP_LOAD = 16'h0002;
   localparam logic [15:0] FORMAT_MASK = 16'h0007;
   localparam logic [15:0] ENC_MODE_MASK = 16'h0001;

   // Field positions
   localparam int unsigned FMT_IO_UNIT = 0;
   localparam int unsigned FMT_COMM_UNIT = 1;
   localparam int unsigned FMT_OVF_EN = 2;
   localparam int unsigned ST_LOST = 0;
   localparam int unsigned ST_BATT = 1;
   localparam int unsigned ST_TURN_OVF = 2;
   localparam int unsigned ST_PUU_OVF = 3;
   localparam int unsigned ST_W = 5;

   // Checksum constants
   localparam logic [15:0] CS_ADD0 = 16'ha700;
   localparam logic [15:0] CS_ADD1 = 16'h605a;
   localparam logic [15:0] CS_ADD2 = 16'h30a5;
   localparam logic [15:0] CS_FINAL = 16'h5a06;

   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_CONFIRM = 6'h02,
      S_WAIT_REQ = 6'h04,
      S_PRESENT = 6'h08,
      S_ERROR = 6'h10,
      S_DONE = 6'h20
   } rd_state_t;

endpackage

// ---- src/abs_checksum.sv ----
`timescale 1ns/10ps
module abs_checksum (
   input wire logic [15:0] word0,
   input wire logic [15:0] word1,
   input wire logic [15:0] word2,
   input wire logic [15:0] word3,
   output logic [15:0] sum
);
   typedef struct packed {
      logic [15:0] acc;
   } cs_t;

   cs_t c;

   // Unsigned 16-bit chain, carries dropped
   always_comb begin
      c.acc = 16'(word0 + abs_readout_pkg::CS_ADD0);
      c.acc = 16'((c.acc ^ word1) + abs_readout_pkg::CS_ADD1);
      c.acc = 16'((c.acc ^ word2) + abs_readout_pkg::CS_ADD2);
      c.acc = 16'((c.acc ^ word3) + abs_readout_pkg::CS_FINAL);
   end

   assign sum = c.acc;
endmodule

// ---- src/confirm_timer.sv ----
`timescale 1ns/10ps
module confirm_timer #(
   parameter int W = 40
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic level,
   input wire logic [W-1:0] target,
   output logic done
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } tmr_t;

   tmr_t r;
   tmr_t n;

   // Counts cycles the level has held, saturating at the target
   always_comb begin
      n = r;
      if (!level) begin
         n.cnt = '0;
      end else if (r.cnt < target) begin
         n.cnt = W'(r.cnt + 1'b1);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign done = level && (r.cnt >= target);
endmodule

// ---- src/absolute_position_readout.sv ----
// Notes on behaviour
// - Homing write needs prior unlock value 271
// - Parameter homing blocked in path register mode
// - Unit bit 0: checksum, position, zero, status
// - Unit bit 1: checksum, pulse, turns, status
// - Checksum: add/xor chain, 16-bit unsigned
// - Enable confirmed after debounce, pins reassigned
// - Falling request means read request
// - After Tq, present bit and raise ready in the same cycle
// - After Tn high request, drop ready
// - No acknowledge within Tr: error, abort
// - Error clears when enable seen low
// - After 80 bits, pins return to normal
// - Lost, battery or turn overflow at confirm: error
// - Snapshot copies status and position parameters
// - Snapshot 2 also reloads drive coordinate
// - Snapshot parameter self-clears when data valid
// - Lost or turn overflow status marks position invalid
// - Absolute mode needs absolute motor, boot-effective
// - Format bits: io unit, comm unit, alarms
// - Status word bits 0-4, rest zero
`timescale 1ns/10ps
module absolute_position_readout #(
   parameter int unsigned MS_CYCLES = abs_readout_pkg::MS_CYCLES_DEF
) (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic PAR_WE,
   input wire logic PAR_RE,
   input wire logic [15:0] PAR_ADDR,
   input wire logic [31:0] PAR_WDATA,
   output logic [31:0] PAR_RDATA,
   input wire logic READOUT_ENABLE,
   input wire logic GENERAL_INPUT_4,
   input wire logic ORIG_OUTPUT_2,
   input wire logic ORIG_OUTPUT_3,
   output logic GENERAL_OUTPUT_2,
   output logic GENERAL_OUTPUT_3,
   output logic INPUT_4_FUNC,
   output logic PINS_REASSIGNED,
   output logic READOUT_ERROR,
   input wire logic [4:0] ENC_STATUS,
   input wire logic [15:0] ENC_TURNS,
   input wire logic [31:0] ENC_PULSE,
   input wire logic [31:0] ENC_USER_POS,
   input wire logic ENC_MOTOR_ABSOLUTE,
   input wire logic ENC_MODE_STORED,
   input wire logic PATH_REGISTER_MODE,
   output logic HOME_START,
   output logic COORD_LOAD,
   output logic ABSOLUTE_MODE_FLAG,
   output logic ENC_MODE_FAULT,
   output logic POSITION_INVALID,
   output logic OVERFLOW_ALARM
);
   localparam int unsigned TW = abs_readout_pkg::TIME_W;

   typedef struct packed {
      abs_readout_pkg::rd_state_t st;
      logic [79:0] frame;
      logic [6:0] bit_idx;
      logic [39:0] tr_cnt;
      logic sdata;
      logic ready;
      logic err;
      logic swapped;
      logic in4_hold;
      logic out2;
      logic out3;
      logic in4_func;
      logic [15:0] unlock;
      logic [15:0] debounce;
      logic [15:0] enc_mode;
      logic [15:0] fmt;
      logic [15:0] snap;
      logic [15:0] status;
      logic [31:0] turns;
      logic [31:0] pulse;
      logic mode_abs;
      logic boot_done;
      logic home_go;
      logic coord_load;
      logic [31:0] rdata;
   } core_t;

   core_t r;
   core_t n;

   logic [TW-1:0] ts_target;
   logic [TW-1:0] tq_target;
   logic [TW-1:0] tn_target;
   logic [TW-1:0] tr_limit;
   logic ts_done;
   logic tq_done;
   logic tn_done;
   logic [15:0] w0;
   logic [15:0] w1;
   logic [31:0] pos;
   logic [15:0] csum;
   logic enc_fault;

   // Register read decode
   function automatic logic [31:0] reg_read(input core_t s, input logic [15:0] addr);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (addr)
         abs_readout_pkg::ADDR_SNAPSHOT: v = {16'h0000, s.snap};
         abs_readout_pkg::ADDR_STATUS: v = {16'h0000, s.status};
         abs_readout_pkg::ADDR_TURNS: v = s.turns;
         abs_readout_pkg::ADDR_PULSE: v = s.pulse;
         abs_readout_pkg::ADDR_UNLOCK: v = {16'h0000, s.unlock};
         abs_readout_pkg::ADDR_DEBOUNCE: v = {16'h0000, s.debounce};
         abs_readout_pkg::ADDR_ENC_MODE: v = {16'h0000, s.enc_mode};
         abs_readout_pkg::ADDR_FORMAT: v = {16'h0000, s.fmt};
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // Handshake timing targets
   assign ts_target = TW'((TW'(r.debounce) + TW'(abs_readout_pkg::TS_ADD_MIN_MS))
                          * TW'(MS_CYCLES));
   assign tq_target = TW'(TW'(abs_readout_pkg::TQ_MS) * TW'(MS_CYCLES));
   assign tn_target = TW'(TW'(abs_readout_pkg::TN_MS) * TW'(MS_CYCLES));
   assign tr_limit = TW'(TW'(abs_readout_pkg::TR_MAX_MS) * TW'(MS_CYCLES));

   confirm_timer #(.W(TW)) u_ts (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .level(READOUT_ENABLE && (r.st == abs_readout_pkg::S_CONFIRM)),
      .target(ts_target),
      .done(ts_done)
   );

   confirm_timer #(.W(TW)) u_tq (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .level(!GENERAL_INPUT_4 && (r.st == abs_readout_pkg::S_WAIT_REQ)),
      .target(tq_target),
      .done(tq_done)
   );

   confirm_timer #(.W(TW)) u_tn (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .level(GENERAL_INPUT_4 && (r.st == abs_readout_pkg::S_PRESENT)),
      .target(tn_target),
      .done(tn_done)
   );

   // Frame words by io unit select
   always_comb begin
      w0 = {11'h000, ENC_STATUS};
      if (r.fmt[abs_readout_pkg::FMT_IO_UNIT]) begin
         w1 = ENC_TURNS;
         pos = ENC_PULSE;
      end else begin
         w1 = 16'h0000;
         pos = ENC_USER_POS;
      end
   end

   abs_checksum u_cs (
      .word0(w0),
      .word1(w1),
      .word2(pos[15:0]),
      .word3(pos[31:16]),
      .sum(csum)
   );

   assign enc_fault = ENC_STATUS[abs_readout_pkg::ST_LOST]
                      | ENC_STATUS[abs_readout_pkg::ST_BATT]
                      | ENC_STATUS[abs_readout_pkg::ST_TURN_OVF];

   always_comb begin
      n = r;
      n.home_go = 1'b0;
      n.coord_load = 1'b0;

      // Stored encoder mode applies once after power-up
      if (!r.boot_done) begin
         n.boot_done = 1'b1;
         n.enc_mode = {15'h0000, ENC_MODE_STORED};
         n.mode_abs = ENC_MODE_STORED;
      end

      // Snapshot completes one cycle after its write
      if (r.snap != abs_readout_pkg::RST_PARAM16) begin
         n.status = {11'h000, ENC_STATUS};
         if (r.fmt[abs_readout_pkg::FMT_COMM_UNIT]) begin
            n.turns = {{16{ENC_TURNS[15]}}, ENC_TURNS};
            n.pulse = ENC_PULSE;
         end else begin
            n.turns = abs_readout_pkg::RST_PARAM32;
            n.pulse = ENC_USER_POS;
         end
         n.coord_load = (r.snap == abs_readout_pkg::SNAP_LOAD);
         n.snap = abs_readout_pkg::RST_PARAM16;
      end

      // Parameter writes; a new snapshot write beats the self-clear
      if (PAR_WE) begin
         case (PAR_ADDR)
            abs_readout_pkg::ADDR_UNLOCK: n.unlock = PAR_WDATA[15:0];
            abs_readout_pkg::ADDR_DEBOUNCE: n.debounce = PAR_WDATA[15:0];
            abs_readout_pkg::ADDR_ENC_MODE: begin
               n.enc_mode = PAR_WDATA[15:0] & abs_readout_pkg::ENC_MODE_MASK;
            end
            abs_readout_pkg::ADDR_FORMAT: begin
               n.fmt = PAR_WDATA[15:0] & abs_readout_pkg::FORMAT_MASK;
            end
            abs_readout_pkg::ADDR_HOMING: begin
               n.home_go = (PAR_WDATA[15:0] == abs_readout_pkg::HOME_GO)
                           && (r.unlock == abs_readout_pkg::UNLOCK_KEY)
                           && !PATH_REGISTER_MODE;
            end
            abs_readout_pkg::ADDR_SNAPSHOT: begin
               if ((PAR_WDATA[15:0] == abs_readout_pkg::SNAP_READ)
                   || (PAR_WDATA[15:0] == abs_readout_pkg::SNAP_LOAD)) begin
                  n.snap = PAR_WDATA[15:0];
               end
            end
            default: n.unlock = r.unlock;
         endcase
      end

      if (PAR_RE) begin
         n.rdata = reg_read(r, PAR_ADDR);
      end

      // Bit-serial readout handshake
      if (!READOUT_ENABLE) begin
         n.st = abs_readout_pkg::S_IDLE;
         n.err = 1'b0;
         n.swapped = 1'b0;
         n.ready = 1'b0;
         n.sdata = 1'b0;
      end else begin
         case (r.st)
            abs_readout_pkg::S_IDLE: begin
               n.st = abs_readout_pkg::S_CONFIRM;
            end
            abs_readout_pkg::S_CONFIRM: begin
               if (ts_done) begin
                  if (enc_fault) begin
                     n.err = 1'b1;
                     n.st = abs_readout_pkg::S_ERROR;
                  end else begin
                     n.frame = {csum, pos, w1, w0};
                     n.swapped = 1'b1;
                     n.in4_hold = GENERAL_INPUT_4;
                     n.bit_idx = 7'h00;
                     n.st = abs_readout_pkg::S_WAIT_REQ;
                  end
               end
            end
            abs_readout_pkg::S_WAIT_REQ: begin
               if (tq_done) begin
                  n.sdata = r.frame[r.bit_idx];
                  n.ready = 1'b1;
                  n.tr_cnt = '0;
                  n.st = abs_readout_pkg::S_PRESENT;
               end
            end
            abs_readout_pkg::S_PRESENT: begin
               if (!GENERAL_INPUT_4) begin
                  n.tr_cnt = TW'(r.tr_cnt + 1'b1);
               end
               if (tn_done) begin
                  n.ready = 1'b0;
                  if (r.bit_idx == abs_readout_pkg::LAST_BIT) begin
                     n.swapped = 1'b0;
                     n.st = abs_readout_pkg::S_DONE;
                  end else begin
                     n.bit_idx = 7'(r.bit_idx + 1'b1);
                     n.st = abs_readout_pkg::S_WAIT_REQ;
                  end
               end else if (r.tr_cnt >= tr_limit) begin
                  n.err = 1'b1;
                  n.ready = 1'b0;
                  n.swapped = 1'b0;
                  n.st = abs_readout_pkg::S_ERROR;
               end
            end
            abs_readout_pkg::S_ERROR: n.st = abs_readout_pkg::S_ERROR;
            abs_readout_pkg::S_DONE: n.st = abs_readout_pkg::S_DONE;
            default: n.st = abs_readout_pkg::S_IDLE;
         endcase
      end

      // Pin function multiplexing, data held with ready
      n.out2 = n.swapped ? n.ready : ORIG_OUTPUT_2;
      n.out3 = n.swapped ? n.sdata : ORIG_OUTPUT_3;
      n.in4_func = n.swapped ? n.in4_hold : GENERAL_INPUT_4;
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         r.st <= abs_readout_pkg::S_IDLE;
         r.frame <= '0;
         r.bit_idx <= 7'h00;
         r.tr_cnt <= '0;
         r.sdata <= 1'b0;
         r.ready <= 1'b0;
         r.err <= 1'b0;
         r.swapped <= 1'b0;
         r.in4_hold <= 1'b0;
         r.out2 <= 1'b0;
         r.out3 <= 1'b0;
         r.in4_func <= 1'b0;
         r.unlock <= abs_readout_pkg::RST_PARAM16;
         r.debounce <= abs_readout_pkg::RST_DEBOUNCE;
         r.enc_mode <= abs_readout_pkg::RST_PARAM16;
         r.fmt <= abs_readout_pkg::RST_PARAM16;
         r.snap <= abs_readout_pkg::RST_PARAM16;
         r.status <= abs_readout_pkg::RST_PARAM16;
         r.turns <= abs_readout_pkg::RST_PARAM32;
         r.pulse <= abs_readout_pkg::RST_PARAM32;
         r.mode_abs <= 1'b0;
         r.boot_done <= 1'b0;
         r.home_go <= 1'b0;
         r.coord_load <= 1'b0;
         r.rdata <= abs_readout_pkg::RST_PARAM32;
      end else begin
         r <= n;
      end
   end

   assign PAR_RDATA = r.rdata;
   assign GENERAL_OUTPUT_2 = r.out2;
   assign GENERAL_OUTPUT_3 = r.out3;
   assign INPUT_4_FUNC = r.in4_func;
   assign PINS_REASSIGNED = r.swapped;
   assign READOUT_ERROR = r.err;
   assign HOME_START = r.home_go;
   assign COORD_LOAD = r.coord_load;
   assign ABSOLUTE_MODE_FLAG = r.mode_abs;
   assign ENC_MODE_FAULT = r.mode_abs && !ENC_MOTOR_ABSOLUTE;
   assign POSITION_INVALID = r.status[abs_readout_pkg::ST_LOST]
                             | r.status[abs_readout_pkg::ST_TURN_OVF];
   assign OVERFLOW_ALARM = r.fmt[abs_readout_pkg::FMT_OVF_EN]
                           && (r.fmt[abs_readout_pkg::FMT_IO_UNIT]
                               ? ENC_STATUS[abs_readout_pkg::ST_TURN_OVF]
                               : ENC_STATUS[abs_readout_pkg::ST_PUU_OVF]);
endmodule

// ---- testbench/abs_readout_chk.sv ----
`timescale 1ns/10ps
module abs_readout_chk #(
   parameter int unsigned MS_CYCLES = 10
) (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic PAR_WE,
   input wire logic [15:0] PAR_ADDR,
   input wire logic [31:0] PAR_WDATA,
   input wire logic READOUT_ENABLE,
   input wire logic GENERAL_INPUT_4,
   input wire logic GENERAL_OUTPUT_2,
   input wire logic GENERAL_OUTPUT_3,
   input wire logic PINS_REASSIGNED,
   input wire logic READOUT_ERROR,
   input wire logic PATH_REGISTER_MODE,
   input wire logic HOME_START,
   input wire logic COORD_LOAD,
   input wire logic ABSOLUTE_MODE_FLAG
);
   localparam int TRC = 200 * MS_CYCLES;
   int low_n, high_n, en_n, stuck_n;
   logic unl;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_B);
   // Run lengths of request, enable and unanswered ready
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         low_n <= 0;
         high_n <= 0;
         en_n <= 0;
         stuck_n <= 0;
         unl <= 1'b0;
      end else begin
         low_n <= GENERAL_INPUT_4 ? 0 : low_n + 1;
         high_n <= GENERAL_INPUT_4 ? high_n + 1 : 0;
         en_n <= READOUT_ENABLE ? en_n + 1 : 0;
         stuck_n <= (GENERAL_OUTPUT_2 && !GENERAL_INPUT_4 && PINS_REASSIGNED) ? stuck_n + 1 : 0;
         if (PAR_WE && PAR_ADDR == 16'h0210) begin
            unl <= PAR_WDATA[15:0] == 16'h010f;
         end
      end
   end
   sequence snap_wr(logic [15:0] v);
      PAR_WE && PAR_ADDR == 16'h0062 && PAR_WDATA[15:0] == v;
   endsequence
   sequence load_pulse;
      ##2 COORD_LOAD ##1 !COORD_LOAD;
   endsequence
   a_home_write_gate: assert property (
      HOME_START |-> $past(PAR_WE) && !$past(PATH_REGISTER_MODE)
         && $past(PAR_ADDR) == 16'h028e && $past(PAR_WDATA[15:0]) == 16'h0001 && $past(unl)
   ) else $error("home pulse without homing write");
   a_snap_load: assert property (
      snap_wr(16'h0002) |-> load_pulse
   ) else $error("snapshot 2 gave no load pulse");
   a_snap_no_load: assert property (
      snap_wr(16'h0001) |-> ##1 !COORD_LOAD [*3]
   ) else $error("snapshot 1 gave a load pulse");
   a_pin_confirm: assert property (
      $rose(PINS_REASSIGNED) |-> en_n >= 4 * MS_CYCLES
   ) else $error("pins reassigned before debounce");
   a_ready_rise: assert property (
      $rose(GENERAL_OUTPUT_2) && $past(PINS_REASSIGNED) |-> low_n >= MS_CYCLES
   ) else $error("ready rose too early");
   a_ready_fall: assert property (
      $fell(GENERAL_OUTPUT_2) && PINS_REASSIGNED |-> high_n >= MS_CYCLES
   ) else $error("ready fell too early");
   a_data_hold: assert property (
      GENERAL_OUTPUT_2 && $past(GENERAL_OUTPUT_2) && PINS_REASSIGNED |-> $stable(GENERAL_OUTPUT_3)
   ) else $error("serial data moved under ready");
   a_err_timeout: assert property (
      stuck_n == TRC - 3 |-> ##[0:6] READOUT_ERROR
   ) else $error("no error after ack timeout");
   a_err_cause: assert property (
      $rose(READOUT_ERROR) && $past(PINS_REASSIGNED) |-> stuck_n >= TRC - 6
   ) else $error("error raised before timeout");
   a_err_clear: assert property (
      !READOUT_ENABLE ##1 !READOUT_ENABLE |-> !READOUT_ERROR
   ) else $error("error held with enable low");
   a_mode_boot: assert property (
      $changed(ABSOLUTE_MODE_FLAG) |-> !$past(RST_B, 2)
   ) else $error("mode flag changed after boot");
endmodule

// ---- testbench/abs_host_model.sv ----
`timescale 1ns/10ps
module abs_host_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic go,
   input wire logic [6:0] stall_at,
   input wire logic ready,
   input wire logic data,
   input wire logic reassigned,
   output logic en,
   output logic req,
   output logic [79:0] frame,
   output logic done
);
   logic [6:0] idx;
   logic [1:0] ph;
   assign done = ph == 2'd3;
   always @(negedge clk or negedge rst_b) begin
      if (!rst_b || !go) begin
         en <= 1'b0;
         req <= 1'b1;
         idx <= 7'h00;
         ph <= 2'd0;
      end else begin
         en <= 1'b1;
         case (ph)
            2'd0: if (reassigned) begin
               req <= 1'b0;
               ph <= 2'd1;
            end
            2'd1: if (ready && idx != stall_at) begin
               frame[idx] <= data;
               req <= 1'b1;
               ph <= 2'd2;
            end
            2'd2: if (!ready) begin
               idx <= idx + 7'h01;
               req <= idx == 7'h4f;
               ph <= (idx == 7'h4f) ? 2'd3 : 2'd1;
            end
            default: ;
         endcase
      end
   end
endmodule

// ---- testbench/absolute_position_readout_tb_top.sv ----
`timescale 1ns/10ps
module absolute_position_readout_tb_top;
   logic REF_CLK = 1'b0, RST_B = 1'b0, PAR_WE = 1'b0, PAR_RE = 1'b0, go = 1'b0;
   logic [15:0] PAR_ADDR = 16'h0000, ENC_TURNS = 16'h8003;
   logic [31:0] PAR_WDATA = 32'h0, ENC_PULSE = 32'h0013_87ff, ENC_USER_POS = 32'hfedc_ba98;
   logic ORIG_OUTPUT_2 = 1'b1, ORIG_OUTPUT_3 = 1'b0, PATH_REGISTER_MODE = 1'b0;
   logic ENC_MOTOR_ABSOLUTE = 1'b0, ENC_MODE_STORED = 1'b1;
   logic [4:0] ENC_STATUS = 5'h10;
   logic [6:0] stall_at = 7'h7f;
   logic [31:0] PAR_RDATA;
   logic [79:0] frame;
   logic READOUT_ENABLE, GENERAL_INPUT_4, GENERAL_OUTPUT_2, GENERAL_OUTPUT_3, INPUT_4_FUNC;
   logic PINS_REASSIGNED, READOUT_ERROR, HOME_START, COORD_LOAD, ABSOLUTE_MODE_FLAG;
   logic ENC_MODE_FAULT, POSITION_INVALID, OVERFLOW_ALARM, done;
   int failures = 0, checked = 0, cycles = 0, n_home = 0, n_load = 0;
   always #2.5 REF_CLK = ~REF_CLK;
   absolute_position_readout #(.MS_CYCLES(10)) i_dut (
      .REF_CLK(REF_CLK), .RST_B(RST_B), .PAR_WE(PAR_WE), .PAR_RE(PAR_RE),
      .PAR_ADDR(PAR_ADDR), .PAR_WDATA(PAR_WDATA), .PAR_RDATA(PAR_RDATA),
      .READOUT_ENABLE(READOUT_ENABLE), .GENERAL_INPUT_4(GENERAL_INPUT_4),
      .ORIG_OUTPUT_2(ORIG_OUTPUT_2), .ORIG_OUTPUT_3(ORIG_OUTPUT_3),
      .GENERAL_OUTPUT_2(GENERAL_OUTPUT_2), .GENERAL_OUTPUT_3(GENERAL_OUTPUT_3),
      .INPUT_4_FUNC(INPUT_4_FUNC), .PINS_REASSIGNED(PINS_REASSIGNED),
      .READOUT_ERROR(READOUT_ERROR), .ENC_STATUS(ENC_STATUS), .ENC_TURNS(ENC_TURNS),
      .ENC_PULSE(ENC_PULSE), .ENC_USER_POS(ENC_USER_POS),
      .ENC_MOTOR_ABSOLUTE(ENC_MOTOR_ABSOLUTE), .ENC_MODE_STORED(ENC_MODE_STORED),
      .PATH_REGISTER_MODE(PATH_REGISTER_MODE), .HOME_START(HOME_START),
      .COORD_LOAD(COORD_LOAD), .ABSOLUTE_MODE_FLAG(ABSOLUTE_MODE_FLAG),
      .ENC_MODE_FAULT(ENC_MODE_FAULT), .POSITION_INVALID(POSITION_INVALID),
      .OVERFLOW_ALARM(OVERFLOW_ALARM)
   );
   abs_host_model i_host (
      .clk(REF_CLK), .rst_b(RST_B), .go(go), .stall_at(stall_at),
      .ready(GENERAL_OUTPUT_2), .data(GENERAL_OUTPUT_3), .reassigned(PINS_REASSIGNED),
      .en(READOUT_ENABLE), .req(GENERAL_INPUT_4), .frame(frame), .done(done)
   );
   task automatic tally_and_finish();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [79:0] s, input logic [79:0] e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(negedge REF_CLK);
      PAR_WE = 1'b1;
      PAR_ADDR = a;
      PAR_WDATA = d;
      @(negedge REF_CLK);
      PAR_WE = 1'b0;
   endtask
   task automatic rd(input string n, input logic [15:0] a, input logic [31:0] e);
      @(negedge REF_CLK);
      PAR_RE = 1'b1;
      PAR_ADDR = a;
      @(negedge REF_CLK);
      PAR_RE = 1'b0;
      chk(n, PAR_RDATA, e);
   endtask
   function automatic logic [79:0] frame_of(input logic unit);
      logic [63:0] lo;
      logic [15:0] s;
      lo = unit ? {ENC_PULSE, ENC_TURNS, 11'h000, ENC_STATUS}
                : {ENC_USER_POS, 16'h0000, 11'h000, ENC_STATUS};
      s = lo[15:0] + 16'ha700;
      s = (s ^ lo[31:16]) + 16'h605a;
      s = (s ^ lo[47:32]) + 16'h30a5;
      s = (s ^ lo[63:48]) + 16'h5a06;
      return {s, lo};
   endfunction
   task automatic readout(input logic [79:0] e, input logic bad, input logic [6:0] stall);
      stall_at = stall;
      go = 1'b1;
      while (!done && !READOUT_ERROR) @(negedge REF_CLK);
      repeat (3) @(negedge REF_CLK);
      chk("error", READOUT_ERROR, bad);
      chk("pins", PINS_REASSIGNED, 0);
      chk("out3_back", GENERAL_OUTPUT_3, ORIG_OUTPUT_3);
      if (!bad) chk("frame", frame, e);
      go = 1'b0;
      repeat (20) @(negedge REF_CLK);
      chk("error_clear", READOUT_ERROR, 0);
   endtask
   always @(posedge REF_CLK) begin
      cycles <= cycles + 1;
      n_home <= n_home + HOME_START;
      n_load <= n_load + COORD_LOAD;
      if (cycles == 30000) begin
         failures = failures + 1;
         tally_and_finish();
      end
   end
   initial begin
      repeat (3) @(negedge REF_CLK);
      RST_B = 1'b1;
      repeat (2) @(negedge REF_CLK);
      chk("mode_flag", ABSOLUTE_MODE_FLAG, 1);
      chk("mode_fault", ENC_MODE_FAULT, 1);
      chk("out2_pass", GENERAL_OUTPUT_2, 1);
      chk("in4_pass", INPUT_4_FUNC, 1);
      ENC_MOTOR_ABSOLUTE = 1'b1;
      ORIG_OUTPUT_2 = 1'b0;
      ORIG_OUTPUT_3 = 1'b1;
      rd("mode", 16'h028a, 1);
      chk("out_pass", {GENERAL_OUTPUT_2, GENERAL_OUTPUT_3}, 2'h1);
      chk("mode_fault", ENC_MODE_FAULT, 0);
      rd("debounce", 16'h0212, 2);
      rd("unmapped", 16'h0300, 0);
      wr(16'h028a, 32'hffff);
      rd("mode", 16'h028a, 1);
      wr(16'h028c, 32'hffff);
      rd("format", 16'h028c, 7);
      wr(16'h028e, 32'h1);
      wr(16'h0210, 32'h0000_010f);
      PATH_REGISTER_MODE = 1'b1;
      wr(16'h028e, 32'h1);
      PATH_REGISTER_MODE = 1'b0;
      wr(16'h028e, 32'h2);
      wr(16'h028e, 32'h1);
      repeat (2) @(negedge REF_CLK);
      chk("home_count", n_home, 1);
      rd("homing", 16'h028e, 0);
      ENC_STATUS = 5'h04;
      @(negedge REF_CLK);
      chk("ovf_alarm", OVERFLOW_ALARM, 1);
      wr(16'h028c, 32'h4);
      chk("ovf_alarm_puu", OVERFLOW_ALARM, 0);
      for (int i = 0; i < 2; i++) begin
         ENC_STATUS = i ? 5'h10 : 5'h04;
         wr(16'h028c, i ? 32'h2 : 32'h0);
         wr(16'h0062, i ? 32'h2 : 32'h1);
         repeat (3) @(negedge REF_CLK);
         rd("snap", 16'h0062, 0);
         rd("status", 16'h0064, {27'h0, ENC_STATUS});
         rd("turns", 16'h0066, i ? {{16{ENC_TURNS[15]}}, ENC_TURNS} : 32'h0);
         rd("pulse", 16'h0068, i ? ENC_PULSE : ENC_USER_POS);
         chk("invalid", POSITION_INVALID, (i == 0));
      end
      chk("load_count", n_load, 1);
      wr(16'h028c, 32'h1);
      readout(frame_of(1), 0, 7'h7f);
      wr(16'h028c, 32'h0);
      readout(frame_of(0), 0, 7'h7f);
      readout(0, 1, 7'h05);
      ENC_STATUS = 5'h12;
      readout(0, 1, 7'h7f);
      tally_and_finish();
   end
endmodule
bind absolute_position_readout abs_readout_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (
   .REF_CLK(REF_CLK), .RST_B(RST_B), .PAR_WE(PAR_WE), .PAR_ADDR(PAR_ADDR),
   .PAR_WDATA(PAR_WDATA), .READOUT_ENABLE(READOUT_ENABLE),
   .GENERAL_INPUT_4(GENERAL_INPUT_4), .GENERAL_OUTPUT_2(GENERAL_OUTPUT_2),
   .GENERAL_OUTPUT_3(GENERAL_OUTPUT_3), .PINS_REASSIGNED(PINS_REASSIGNED),
   .READOUT_ERROR(READOUT_ERROR), .PATH_REGISTER_MODE(PATH_REGISTER_MODE),
   .HOME_START(HOME_START), .COORD_LOAD(COORD_LOAD), .ABSOLUTE_MODE_FLAG(ABSOLUTE_MODE_FLAG)
);
